// file: hw/iic_chan.sv
module iic_chan import iic_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic scan_tick,
  input wire logic ms_tick,
  input wire logic [VW-1:0] volt,
  input wire logic [THW-1:0] act_thr,
  input wire logic [THW-1:0] rel_thr,
  input wire logic [DW-1:0] pick,
  input wire logic [DW-1:0] drop,
  input wire logic sense,
  input wire logic ac,
  input wire logic cnt_clr,
  output logic state,
  output logic [CW-1:0] cnt,
  output logic rise,
  output logic fall
);
  logic energized;
  logic [TW-1:0] timer;
  logic [VW-1:0] act_mv, rel_mv;
  logic [TW-1:0] target;
  logic next_energized, raw, expire;

  // Threshold scaling and hysteresis; AC mode forces release to 10 %
  assign act_mv = VW'(act_thr * MV_PER_STEP);
  assign rel_mv = ac ? VW'(act_thr * AC_MV_PER_STEP)
                     : VW'(rel_thr * MV_PER_STEP);
  assign next_energized = (volt > act_mv) ? 1'b1
                        : (volt < rel_mv) ? 1'b0
                        : energized;
  assign raw = energized ^ sense;
  assign target = state ? TW'(drop) + (ac ? TW'(AC_DROP_MS) : '0)
                        : TW'(pick);
  assign expire = (raw != state) && (timer >= target);

  // Energized level only moves on the scan strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      energized <= 1'b0;
    end else if (scan_tick) begin
      energized <= next_energized;
    end
  end

  // Delay timer restarts whenever raw agrees with the reported state
  always_ff @(posedge clk) begin
    if (srst) begin
      timer <= '0;
    end else if (raw == state || expire) begin
      timer <= '0;
    end else if (ms_tick) begin
      timer <= timer + TW'(1);
    end
  end

  // Reported state and one-cycle edge pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      if (expire) begin
        state <= raw;
      end
      rise <= expire & raw;
      fall <= expire & ~raw;
    end
  end

  // Counting wins over a clear in the same cycle, so no edge is lost
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= '0;
    end else if (expire && raw) begin
      cnt <= cnt_clr ? CW'(1) : cnt + CW'(1);
    end else if (cnt_clr) begin
      cnt <= '0;
    end
  end

  a_zero_pick: assert property (@(posedge clk) disable iff (srst)
    (!state && raw && pick == '0) |=> state)
    else $error("zero pick-up delay did not switch at once");
  a_no_early_drop: assert property (@(posedge clk) disable iff (srst)
    (state && !raw && timer < target) |=> state)
    else $error("state dropped before its delay ran out");
  a_hyst_hold: assert property (@(posedge clk) disable iff (srst)
    (scan_tick && volt <= act_mv && volt >= rel_mv) |=> $stable(energized))
    else $error("raw level moved inside the hysteresis band");
  a_cancel: assert property (@(posedge clk) disable iff (srst)
    (raw == state) |=> (timer == '0))
    else $error("pending delay not cancelled");
  a_count_rise: assert property (@(posedge clk) disable iff (srst)
    $rose(state) |-> (cnt == $past(cnt) + CW'(1) || cnt == CW'(1)))
    else $error("counter missed a rising transition");
  a_count_clr: assert property (@(posedge clk) disable iff (srst)
    (cnt_clr && !(expire && raw)) |=> (cnt == '0))
    else $error("counter clear had no effect");
endmodule // iic_chan

// file: hw/iic_eight_input_card.sv
module iic_eight_input_card import iic_pkg::*; #(
  parameter int MS_CYC = MS_CYCLES,
  parameter int FIRST_IDX = FIRST_INPUT
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic [NUM_CH*VW-1:0] VOLT_MV,
  output logic [NUM_CH-1:0] IN_STATE,
  output logic IRQ,
  input wire logic [AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  localparam int MSW = $clog2(MS_CYC + 1);
  localparam int IW = 2 * NUM_CH;

  logic [MSW-1:0] ms_cnt;
  logic [2:0] scan_cnt;
  logic ms_tick, scan_tick;
  logic aw_got, w_got;
  logic [AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [IW-1:0] istat, ien;
  logic [NUM_CH-1:0] sense, acmode;
  logic [THW-1:0] act_thr [NUM_CH];
  logic [THW-1:0] rel_thr [NUM_CH];
  logic [DW-1:0] pick [NUM_CH];
  logic [DW-1:0] drop [NUM_CH];
  logic [CW-1:0] cnt [NUM_CH];
  logic [VW-1:0] volt [NUM_CH];
  logic [NUM_CH-1:0] rise, fall, cnt_clr;
  logic [31:0] rd_val;
  logic rd_ok;

  // Keep the strobed bytes of a write, the rest from the old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Millisecond tick and the scan strobe every fifth millisecond
  assign ms_tick = (ms_cnt == MSW'(MS_CYC - 1));
  assign scan_tick = ms_tick && (scan_cnt == 3'(SCAN_MS - 1));
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ms_cnt <= '0;
      scan_cnt <= '0;
    end else begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + MSW'(1);
      if (scan_tick) begin
        scan_cnt <= '0;
      end else if (ms_tick) begin
        scan_cnt <= scan_cnt + 3'h1;
      end
    end
  end

  // Write decode, on the held address once both halves have arrived
  logic do_wr, wg, wc;
  logic [2:0] w_ch, w_sel;
  logic [31:0] w_old;
  assign do_wr = aw_got && w_got && !S_AXI_BVALID;
  assign wg = (aw_addr[AW-1:5] == '0);
  assign wc = (aw_addr[AW-1:8] == CH_PAGE) && (aw_addr[4:2] <= SEL_VOLT);
  assign w_ch = aw_addr[7:5];
  assign w_sel = aw_addr[4:2];
  assign w_old = merge(32'h0, w_data, w_strb);

  // Bus handshake: address and data may come in either order
  assign S_AXI_AWREADY = !aw_got;
  assign S_AXI_WREADY = !w_got;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_got) begin
        aw_got <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (do_wr) begin
        aw_got <= 1'b0;
      end
      if (S_AXI_WVALID && !w_got) begin
        w_got <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (do_wr) begin
        w_got <= 1'b0;
      end
      if (do_wr) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (wg || wc) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Global write pulses; read-only words accept and ignore writes
  logic wr_ien, wr_sense, wr_ac;
  logic [IW-1:0] iclr;
  assign wr_ien = do_wr && wg && aw_addr == OFS_IEN;
  assign wr_sense = do_wr && wg && aw_addr == OFS_SENSE;
  assign wr_ac = do_wr && wg && aw_addr == OFS_ACMODE;
  assign iclr = (do_wr && wg && aw_addr == OFS_ICLR) ? w_old[IW-1:0] : '0;
  assign cnt_clr = (do_wr && wg && aw_addr == OFS_CCLR)
                 ? w_old[NUM_CH-1:0] : '0;

  // Sticky events: a new event wins over a clear in the same cycle
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      istat <= '0;
      ien <= '0;
      sense <= {NUM_CH{SENSE_NO}};
      acmode <= '0;
      IRQ <= 1'b0;
    end else begin
      istat <= (istat & ~iclr) | {fall, rise};
      if (wr_ien) ien <= IW'(merge(32'(ien), w_data, w_strb));
      if (wr_sense) sense <= NUM_CH'(merge(32'(sense), w_data, w_strb));
      if (wr_ac) acmode <= NUM_CH'(merge(32'(acmode), w_data, w_strb));
      IRQ <= |(istat & ien);
    end
  end

  // One conditioner per channel with its own settings
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic hit;
      assign hit = do_wr && wc && w_ch == 3'(g);
      assign volt[g] = VOLT_MV[g*VW +: VW];
      always_ff @(posedge MCLK) begin
        if (SRST) begin
          act_thr[g] <= ACT_RST;
          rel_thr[g] <= REL_RST;
          pick[g] <= DLY_RST;
          drop[g] <= DLY_RST;
        end else if (hit) begin
          if (w_sel == SEL_ACT) begin
            act_thr[g] <= THW'(merge(32'(act_thr[g]), w_data, w_strb));
          end
          if (w_sel == SEL_REL) begin
            rel_thr[g] <= THW'(merge(32'(rel_thr[g]), w_data, w_strb));
          end
          if (w_sel == SEL_PICK) begin
            pick[g] <= DW'(merge(32'(pick[g]), w_data, w_strb));
          end
          if (w_sel == SEL_DROP) begin
            drop[g] <= DW'(merge(32'(drop[g]), w_data, w_strb));
          end
        end
      end
      iic_chan u_chan (
        .clk(MCLK),
        .srst(SRST),
        .scan_tick(scan_tick),
        .ms_tick(ms_tick),
        .volt(volt[g]),
        .act_thr(act_thr[g]),
        .rel_thr(rel_thr[g]),
        .pick(pick[g]),
        .drop(drop[g]),
        .sense(sense[g]),
        .ac(acmode[g]),
        .cnt_clr(cnt_clr[g]),
        .state(IN_STATE[g]),
        .cnt(cnt[g]),
        .rise(rise[g]),
        .fall(fall[g])
      );
    end
  endgenerate

  // Read decode straight from the offered address
  logic rg, rc;
  logic [2:0] r_ch, r_sel;
  logic [31:0] ch_val;
  assign rg = (S_AXI_ARADDR[AW-1:5] == '0);
  assign rc = (S_AXI_ARADDR[AW-1:8] == CH_PAGE)
           && (S_AXI_ARADDR[4:2] <= SEL_VOLT);
  assign r_ch = S_AXI_ARADDR[7:5];
  assign r_sel = S_AXI_ARADDR[4:2];
  assign rd_ok = rg || rc;
  always_comb begin
    ch_val = 32'h0;
    unique case (r_sel)
      SEL_ACT: ch_val = 32'(act_thr[r_ch]);
      SEL_REL: ch_val = 32'(rel_thr[r_ch]);
      SEL_PICK: ch_val = 32'(pick[r_ch]);
      SEL_DROP: ch_val = 32'(drop[r_ch]);
      SEL_CNT: ch_val = cnt[r_ch];
      SEL_VOLT: ch_val = 32'(volt[r_ch]);
      default: ch_val = 32'h0;
    endcase
  end
  always_comb begin
    rd_val = 32'h0;
    if (rc) begin
      rd_val = ch_val;
    end else if (rg) begin
      unique case (S_AXI_ARADDR)
        OFS_ISTAT: rd_val = 32'(istat);
        OFS_IEN: rd_val = 32'(ien);
        OFS_STATE: rd_val = 32'(IN_STATE);
        OFS_SENSE: rd_val = 32'(sense);
        OFS_ACMODE: rd_val = 32'(acmode);
        OFS_INFO: rd_val = {16'(FIRST_IDX), 16'(NUM_CH)};
        default: rd_val = 32'h0; // Clear words read as zero
      endcase
    end
  end

  // Read answer is registered one cycle after the address is taken
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_val;
      S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  a_scan_gap: assert property (@(posedge MCLK) disable iff (SRST)
    scan_tick |=> !scan_tick)
    else $error("scan strobes on adjacent cycles");
  a_bvalid_hold: assert property (@(posedge MCLK) disable iff (SRST)
    (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID)
    else $error("write response dropped before ready");
  a_rvalid_hold: assert property (@(posedge MCLK) disable iff (SRST)
    (S_AXI_RVALID && !S_AXI_RREADY) |=> $stable(S_AXI_RDATA))
    else $error("read data changed while waiting");
  a_sticky_rise: assert property (@(posedge MCLK) disable iff (SRST)
    rise[0] |=> istat[0])
    else $error("rise event not latched");
  a_irq_follow: assert property (@(posedge MCLK) disable iff (SRST)
    (istat[0] && ien[0]) |=> IRQ)
    else $error("enabled status did not raise interrupt");
  // Flag and response guards; a stuck flag would hold the interrupt forever
  a_irq_low: assert property (@(posedge MCLK) disable iff (SRST)
    !(|(istat & ien)) |=> !IRQ)
    else $error("interrupt high with no enabled status");
  a_sticky_fall: assert property (@(posedge MCLK) disable iff (SRST)
    fall[0] |=> istat[IRQ_FALL_POS])
    else $error("fall event not latched");
  a_iclr_clear: assert property (@(posedge MCLK) disable iff (SRST)
    (iclr[0] && !rise[0]) |=> !istat[0])
    else $error("status bit survived its clear");
  a_wr_slverr: assert property (@(posedge MCLK) disable iff (SRST)
    (do_wr && !wg && !wc) |=> (S_AXI_BRESP == RESP_SLVERR))
    else $error("unmapped write not refused");
  a_rd_slverr: assert property (@(posedge MCLK) disable iff (SRST)
    (S_AXI_ARVALID && S_AXI_ARREADY && !rd_ok)
    |=> (S_AXI_RRESP == RESP_SLVERR))
    else $error("unmapped read not refused");
endmodule // iic_eight_input_card

// file: hw/iic_pkg.sv
package iic_pkg;
  // Card shape and input numbering
  localparam int NUM_CH = 8;
  localparam int FIRST_INPUT = 0;
  // Timing: clock rate, millisecond tick, scan period, AC extra drop-off
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int SCAN_MS = 5;
  localparam int AC_DROP_MS = 30;
  // Field widths: millivolts, 0.1 V thresholds, ms delays, counters
  localparam int VW = 19;
  localparam int THW = 12;
  localparam int DW = 21;
  localparam int TW = DW + 1;
  localparam int CW = 32;
  localparam int AW = 12;
  // Scaling: one threshold step is 100 mV; AC release is a tenth of that
  localparam int MV_PER_STEP = 100;
  localparam int AC_MV_PER_STEP = 10;
  // Reset values
  localparam logic [THW-1:0] ACT_RST = 12'h370;
  localparam logic [THW-1:0] REL_RST = 12'h258;
  localparam logic [DW-1:0] DLY_RST = 21'h000000;
  localparam logic SENSE_NO = 1'b0;
  // Global registers, byte addresses
  localparam logic [AW-1:0] OFS_ISTAT = 12'h000;
  localparam logic [AW-1:0] OFS_IEN = 12'h004;
  localparam logic [AW-1:0] OFS_ICLR = 12'h008;
  localparam logic [AW-1:0] OFS_STATE = 12'h00c;
  localparam logic [AW-1:0] OFS_SENSE = 12'h010;
  localparam logic [AW-1:0] OFS_ACMODE = 12'h014;
  localparam logic [AW-1:0] OFS_CCLR = 12'h018;
  localparam logic [AW-1:0] OFS_INFO = 12'h01c;
  // Channel window: base + channel * 0x20 + word select * 4
  localparam logic [3:0] CH_PAGE = 4'h1;
  localparam logic [2:0] SEL_ACT = 3'h0;
  localparam logic [2:0] SEL_REL = 3'h1;
  localparam logic [2:0] SEL_PICK = 3'h2;
  localparam logic [2:0] SEL_DROP = 3'h3;
  localparam logic [2:0] SEL_CNT = 3'h4;
  localparam logic [2:0] SEL_VOLT = 3'h5;
  // Interrupt status layout: rises low byte, falls next byte
  localparam int IRQ_FALL_POS = 8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: sim/iic_field.sv
// Field contacts: each channel presents one measured voltage in mV
module iic_field import iic_pkg::*; (
  input wire logic clk,
  input wire logic [NUM_CH*VW-1:0] set_mv,
  output logic [NUM_CH*VW-1:0] volt_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts settle one clock after a change, never mid-cycle
  always_ff @(posedge clk) begin
    volt_mv <= set_mv;
  end
endmodule // iic_field

// file: sim/isolated_input_conditioner_bench.sv
module isolated_input_conditioner_bench import iic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Short ms so a scan is 20 cycles; delays scale with it
  localparam int MSC = 4;
  localparam int SCAN = SCAN_MS * MSC;
  localparam int SLACK = SCAN + MSC + 4;
  logic mclk, srst, awv, wv, bv, bre, arv, rv, rre, awr, wr_rdy, arr, irq;
  logic [AW-1:0] awa, ara;
  logic [31:0] wd, rdd, rd;
  logic [1:0] br, rr, rs;
  logic [NUM_CH*VW-1:0] set_mv, volt, v;
  logic [NUM_CH-1:0] st;
  int err_count, checked, seed, cyc, n, mid;
  int exp_mv [NUM_CH];

  iic_field u_field (.clk(mclk), .set_mv(set_mv), .volt_mv(volt));
  iic_eight_input_card #(.MS_CYC(MSC), .FIRST_IDX(3)) u_dut (
    .MCLK(mclk), .SRST(srst), .VOLT_MV(volt), .IN_STATE(st), .IRQ(irq),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdd), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Watchdog: the whole run needs well under this many cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [AW-1:0] ca(input int ch, input logic [2:0] sel);
    return AW'(12'h100 + ch * 32 + sel * 4);
  endfunction

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic pa, pw;
    @(posedge mclk);
    pa = 1'b1;
    pw = 1'b1;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (pa || pw) begin
      @(posedge mclk);
      if (pa && awr === 1'b1) begin
        pa = 1'b0;
        awv <= 1'b0;
      end
      if (pw && wr_rdy === 1'b1) begin
        pw = 1'b0;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1) @(posedge mclk);
    rs = br;
    bre <= 1'b0;
  endtask

  task automatic rdr(input logic [AW-1:0] a);
    @(posedge mclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge mclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge mclk); while (rv !== 1'b1);
    rd = rdd;
    rs = rr;
    rre <= 1'b0;
  endtask

  // One assignment per step keeps the field vector race free
  task automatic sv(input int ch, input int mv);
    v[ch*VW +: VW] = VW'(mv);
    set_mv <= v;
  endtask

  task automatic wst(input int ch, input logic val);
    n = 0;
    while (st[ch] !== val && n < 400) begin
      @(posedge mclk);
      n++;
    end
  endtask

  initial begin
    {awv, wv, bre, arv, rre, awa, ara, wd, set_mv, v} = '0;
    {err_count, checked, cyc} = '0;
    seed = 32'hd75e;
    srst = 1'b1;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    // Reset values, card numbering, unmapped word
    rdr(ca(0, SEL_ACT));
    chk(rd, 32'h370);
    rdr(ca(7, SEL_REL));
    chk(rd, 32'h258);
    rdr(OFS_SENSE);
    chk(rd, 32'h0);
    rdr(OFS_INFO);
    chk(rd, 32'h00030008);
    rdr(ca(0, 3'h6));
    chk({rd[29:0], rs}, {30'h0, RESP_SLVERR});
    wr(ca(0, 3'h7), 32'hffff);
    chk(rs, RESP_SLVERR);
    $display("test reset done");
    // Own threshold on ch1; ch0 walks through its hysteresis band
    wr(ca(1, SEL_ACT), 32'd100);
    wr(ca(1, SEL_REL), 32'd50);
    chk(rs, RESP_OKAY);
    for (int i = 0; i < NUM_CH; i++) v[i*VW +: VW] = VW'(20000);
    set_mv <= v;
    wst(1, 1'b1);
    chk(st[1:0], 2'b10);
    mid = 60000 + ($unsigned($random(seed)) % 28000);
    exp_mv = '{90000, mid, 59000, mid, 88000, 88100, 0, 0};
    for (int i = 0; i < 6; i++) begin
      sv(0, exp_mv[i]);
      repeat (2 * SCAN + 4) @(posedge mclk);
      chk(st[0], 32'((8'b00100011 >> i) & 1));
    end
    $display("test thresholds done");
    // Zero, pick-up and drop-off delays against the scan
    sv(0, 0);
    wst(0, 1'b0);
    chk(n <= SCAN + 3, 1);
    wr(ca(2, SEL_PICK), 32'd10);
    wr(ca(2, SEL_DROP), 32'd5);
    sv(2, 100000);
    wst(2, 1'b1);
    chk(n >= 10 * MSC && n <= 10 * MSC + SLACK, 1);
    sv(2, 0);
    wst(2, 1'b0);
    chk(n >= 5 * MSC && n <= 5 * MSC + SLACK, 1);
    // Counters: ch0 rose twice, ch2 once; clear is per channel
    rdr(ca(0, SEL_CNT));
    chk(rd, 32'd2);
    wr(OFS_CCLR, 32'h1);
    rdr(ca(0, SEL_CNT));
    chk(rd, 32'd0);
    rdr(ca(2, SEL_CNT));
    chk(rd, 32'd1);
    $display("test delays and counters done");
    // Closed sense reads energised as inactive
    wr(OFS_SENSE, 32'h8);
    sv(3, 0);
    wst(3, 1'b1);
    chk(st[3], 1);
    sv(3, 100000);
    wst(3, 1'b0);
    chk(st[3], 0);
    // AC mode: release at a tenth of activation plus 30 ms
    wr(OFS_ACMODE, 32'h10);
    sv(4, 100000);
    wst(4, 1'b1);
    sv(4, 30000);
    repeat (3 * SCAN) @(posedge mclk);
    chk(st[4], 1);
    sv(4, 5000);
    wst(4, 1'b0);
    chk(n >= AC_DROP_MS * MSC && n <= AC_DROP_MS * MSC + SLACK, 1);
    // Three pulses, each shorter than the pick-up delay but longer together
    wr(ca(5, SEL_PICK), 32'd20);
    repeat (3) begin
      sv(5, 100000);
      repeat (2 * SCAN + 2) @(posedge mclk);
      sv(5, 0);
      repeat (2 * SCAN) @(posedge mclk);
    end
    repeat (40 * MSC) @(posedge mclk);
    chk(st[5], 0);
    $display("test sense ac cancel done");
    // Interrupt: raise, clear, then mask a falling edge
    wr(OFS_ICLR, 32'hffff);
    wr(OFS_IEN, 32'h1);
    chk(irq, 0);
    sv(0, 100000);
    wst(0, 1'b1);
    repeat (3) @(posedge mclk);
    chk(irq, 1);
    rdr(OFS_STATE);
    chk(rd[0], 1);
    wr(OFS_ICLR, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq, 0);
    wr(OFS_IEN, 32'h0);
    sv(0, 0);
    wst(0, 1'b0);
    repeat (3) @(posedge mclk);
    chk(irq, 0);
    rdr(OFS_ISTAT);
    chk(rd[8], 1);
    $display("test interrupt done");
    // Voltage readout over the full 0 to 275 V span
    for (int i = 0; i < NUM_CH; i++) begin
      exp_mv[i] = $unsigned($random(seed)) % 275001;
      v[i*VW +: VW] = VW'(exp_mv[i]);
    end
    set_mv <= v;
    repeat (SCAN + 4) @(posedge mclk);
    for (int i = 0; i < NUM_CH; i++) begin
      rdr(ca(i, SEL_VOLT));
      chk(rd, 32'(exp_mv[i]));
    end
    $display("test voltage done");
    end_of_test();
  end
endmodule // isolated_input_conditioner_bench
